/* File: src/ttu_cfg.svh */
`ifndef TTU_CFG_SVH
`define TTU_CFG_SVH
// ****************************************
// register indices, byte address is four times the index
// ****************************************
`define TTU_IDX_T0_CNT 8'h50
`define TTU_IDX_T0_CMPA 8'h52
`define TTU_IDX_T0_CMPB 8'h54
`define TTU_IDX_T0_CTL 8'h56
`define TTU_IDX_T1_CNT 8'h58
`define TTU_IDX_T1_CMPA 8'h5a
`define TTU_IDX_T1_CMPB 8'h5c
`define TTU_IDX_T1_CTL 8'h5e
`define TTU_IDX_T2_CNT 8'h60
`define TTU_IDX_T2_CMPA 8'h62
`define TTU_IDX_T2_CTL 8'h66
// ****************************************
// control field positions
// ****************************************
`define TTU_B_EN 15
`define TTU_B_GATE 14
`define TTU_B_INT 13
`define TTU_B_RIU 12
`define TTU_B_MC 5
`define TTU_B_RTG 4
`define TTU_B_PRE 3
`define TTU_B_EXT 2
`define TTU_B_ALT 1
`define TTU_B_FREE_RUN_SELECT 0
// ****************************************
// masks, reset values, counts
// ****************************************
`define TTU_CTL_RMASK2 16'ha021
`define TTU_RST16 16'h0000
`define TTU_ONE16 16'h0001
`define TTU_PRESC_ONE 2'h1
`define TTU_PRESC_LAST 2'h3
`define TTU_HI_ZERO 2'h0
`endif

/* File: src/ttu_insync.sv */
`timescale 1ns/1ps
module ttu_insync
  import ttu_pkg::*;
(
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // pin and event
  input wire logic i_pin,
  output logic o_rise
);
  ttu_sync_t st_reg;
  ttu_sync_t st_next;

  // meta is read only by sync, edges come from the settled stages
  always_comb begin
    st_next = st_reg;
    st_next.meta = i_pin;
    st_next.sync = st_reg.meta;
    st_next.prev = st_reg.sync;
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // one pulse per rising transition
  assign o_rise = st_reg.sync && !st_reg.prev;
endmodule

/* File: src/ttu_pkg.sv */
package ttu_pkg;
  localparam int TTU_AW = 12;
  typedef struct packed {
    logic [TTU_AW-1:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } ttu_apb_req_t;
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } ttu_apb_rsp_t;
  typedef struct packed {
    logic en;
    logic int_en;
    logic second_compare_active;
    logic maxcount_flag;
    logic retrigger_select;
    logic pre;
    logic outside_clock_select;
    logic dual_compare_select;
    logic free_run_select;
    logic [15:0] cnt;
    logic [15:0] cmpa;
    logic [15:0] cmpb;
  } ttu_tmr_t;
  typedef struct packed {
    ttu_tmr_t [2:0] tmr;
    logic [1:0] presc;
    ttu_apb_rsp_t rsp;
    logic [2:0] irq;
    logic [1:0] wave;
  } ttu_state_t;
  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
  } ttu_sync_t;
endpackage

/* File: src/ttu_top.sv */
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "ttu_cfg.svh"
// Functional notes
// - a timer counts only while its enable bit is set.
// - a control write changes enable only when the gate bit is written 1; gate reads 0.
// - interrupt bit set raises a request at maxcount, clear raises none.
// - in dual compare mode both compare A and B raise requests.
// - a raised request stays pending when enable is cleared.
// - status bit 12 shows compare B is the active target.
// - maxcount flag sets at every compare match, regardless of interrupt bit.
// - internal source is timer 2 maxcount if prescale bit set, else quarter clock.
// - outside clock select picks the count input pin over internal clock.
// - dual compare counts to A, clears, counts to B, clears, repeats.
// - single compare uses only A and clears at each match.
// - free run keeps going; otherwise the run ends and enable clears.
// - timer 2 has one compare and a reduced control word.
// - a zero compare value counts the full 16-bit range.
// - a match clears the count and takes maxcount actions.
// - internal clock advances the count once per four clocks.
// - prescaled timers step once per timer 2 maxcount.
// - wave outputs follow the alternating compare phases.
// - reset zeroes all control, count and compare registers.
module ttu_top
  import ttu_pkg::*;
(
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // apb slave
  input wire ttu_apb_req_t i_apb,
  output ttu_apb_rsp_t o_apb,
  // count input pins
  input wire logic i_timer0_count_input,
  input wire logic i_timer1_count_input,
  // interrupt controller handshake
  input wire logic [2:0] i_irq_ack,
  output logic [2:0] o_irq_req,
  // wave outputs
  output logic o_timer0_wave_output,
  output logic o_timer1_wave_output
);
  // ****************************************
  // state
  // ****************************************
  ttu_state_t st_reg;
  ttu_state_t st_next;

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [1:0] ext_rise;

  ttu_insync u_sync0 (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_pin(i_timer0_count_input),
    .o_rise(ext_rise[0])
  );

  ttu_insync u_sync1 (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_pin(i_timer1_count_input),
    .o_rise(ext_rise[1])
  );

  // ****************************************
  // apb decode
  // ****************************************
  logic [7:0] idx;
  logic hi_ok;
  logic setup;
  logic wr;
  logic [15:0] wd;
  logic [2:0] wr_cnt;
  logic [2:0] wr_cmpa;
  logic [2:0] wr_cmpb;
  logic [2:0] wr_ctl;

  assign idx = i_apb.paddr[9:2];
  assign hi_ok = i_apb.paddr[TTU_AW-1:10] == `TTU_HI_ZERO;
  assign setup = i_apb.psel && !i_apb.penable;
  // a write lands only at the edge where pready is seen high
  assign wr = i_apb.psel && i_apb.penable && i_apb.pwrite && st_reg.rsp.pready && hi_ok;
  assign wd = i_apb.pwdata[15:0];
  assign wr_cnt[0] = wr && (idx == `TTU_IDX_T0_CNT);
  assign wr_cnt[1] = wr && (idx == `TTU_IDX_T1_CNT);
  assign wr_cnt[2] = wr && (idx == `TTU_IDX_T2_CNT);
  assign wr_cmpa[0] = wr && (idx == `TTU_IDX_T0_CMPA);
  assign wr_cmpa[1] = wr && (idx == `TTU_IDX_T1_CMPA);
  assign wr_cmpa[2] = wr && (idx == `TTU_IDX_T2_CMPA);
  assign wr_cmpb[0] = wr && (idx == `TTU_IDX_T0_CMPB);
  assign wr_cmpb[1] = wr && (idx == `TTU_IDX_T1_CMPB);
  assign wr_cmpb[2] = 1'b0;
  assign wr_ctl[0] = wr && (idx == `TTU_IDX_T0_CTL);
  assign wr_ctl[1] = wr && (idx == `TTU_IDX_T1_CTL);
  assign wr_ctl[2] = wr && (idx == `TTU_IDX_T2_CTL);

  // ****************************************
  // count sources and compare
  // ****************************************
  logic int_tick;
  logic [2:0] tick;
  logic [2:0] hit;
  logic [15:0] cnt_inc [3];
  logic [15:0] cmp_act [3];

  assign int_tick = st_reg.presc == `TTU_PRESC_LAST;
  assign tick[2] = st_reg.tmr[2].en && int_tick;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_src
      // the prescale bit only matters while the pin is not selected
      assign tick[gi] = st_reg.tmr[gi].en && (st_reg.tmr[gi].outside_clock_select ? ext_rise[gi] :
        (st_reg.tmr[gi].pre ? hit[2] : int_tick));
    end
    for (gi = 0; gi < 3; gi++) begin : g_cmp
      assign cnt_inc[gi] = st_reg.tmr[gi].cnt + `TTU_ONE16;
      assign cmp_act[gi] = (st_reg.tmr[gi].dual_compare_select && st_reg.tmr[gi].second_compare_active) ?
        st_reg.tmr[gi].cmpb : st_reg.tmr[gi].cmpa;
      // matching on count+1 makes a zero compare wrap at ffff
      assign hit[gi] = tick[gi] && (cnt_inc[gi] == cmp_act[gi]);
    end
  endgenerate

  // ****************************************
  // read path
  // ****************************************
  function automatic logic [15:0] ctl_rd(input ttu_tmr_t t, input logic is_t2);
    logic [15:0] w;
    w = `TTU_RST16;
    w[`TTU_B_EN] = t.en;
    w[`TTU_B_GATE] = 1'b0;
    w[`TTU_B_INT] = t.int_en;
    w[`TTU_B_RIU] = t.second_compare_active;
    w[`TTU_B_MC] = t.maxcount_flag;
    w[`TTU_B_RTG] = t.retrigger_select;
    w[`TTU_B_PRE] = t.pre;
    w[`TTU_B_EXT] = t.outside_clock_select;
    w[`TTU_B_ALT] = t.dual_compare_select;
    w[`TTU_B_FREE_RUN_SELECT] = t.free_run_select;
    if (is_t2) begin
      w = w & `TTU_CTL_RMASK2;
    end
    return w;
  endfunction

  logic [15:0] rd_word;
  logic rd_hit;

  always_comb begin
    rd_word = `TTU_RST16;
    rd_hit = hi_ok;
    case (idx)
      `TTU_IDX_T0_CNT: rd_word = st_reg.tmr[0].cnt;
      `TTU_IDX_T0_CMPA: rd_word = st_reg.tmr[0].cmpa;
      `TTU_IDX_T0_CMPB: rd_word = st_reg.tmr[0].cmpb;
      `TTU_IDX_T0_CTL: rd_word = ctl_rd(st_reg.tmr[0], 1'b0);
      `TTU_IDX_T1_CNT: rd_word = st_reg.tmr[1].cnt;
      `TTU_IDX_T1_CMPA: rd_word = st_reg.tmr[1].cmpa;
      `TTU_IDX_T1_CMPB: rd_word = st_reg.tmr[1].cmpb;
      `TTU_IDX_T1_CTL: rd_word = ctl_rd(st_reg.tmr[1], 1'b0);
      `TTU_IDX_T2_CNT: rd_word = st_reg.tmr[2].cnt;
      `TTU_IDX_T2_CMPA: rd_word = st_reg.tmr[2].cmpa;
      `TTU_IDX_T2_CTL: rd_word = ctl_rd(st_reg.tmr[2], 1'b1);
      default: rd_hit = 1'b0;
    endcase
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    st_next = st_reg;
    st_next.presc = st_reg.presc + `TTU_PRESC_ONE;
    // zero wait state: pready follows every setup cycle by one clock
    st_next.rsp.pready = setup;
    st_next.rsp.pslverr = 1'b0;
    st_next.rsp.prdata = 32'h0000_0000;
    if (setup) begin
      st_next.rsp.pslverr = !(rd_hit && hi_ok);
      st_next.rsp.prdata = {16'h0000, rd_hit ? rd_word : `TTU_RST16};
    end
    for (int i = 0; i < 3; i++) begin
      // counting
      if (tick[i]) begin
        st_next.tmr[i].cnt = hit[i] ? `TTU_RST16 : cnt_inc[i];
      end
      if (hit[i]) begin
        if (st_reg.tmr[i].dual_compare_select) begin
          st_next.tmr[i].second_compare_active = !st_reg.tmr[i].second_compare_active;
        end
        // single run ends after A alone, or after B in dual mode
        if (!st_reg.tmr[i].free_run_select &&
            (!st_reg.tmr[i].dual_compare_select || st_reg.tmr[i].second_compare_active)) begin
          st_next.tmr[i].en = 1'b0;
        end
      end
      // software writes take priority over the count step
      if (wr_cnt[i]) begin
        st_next.tmr[i].cnt = wd;
      end
      if (wr_cmpa[i]) begin
        st_next.tmr[i].cmpa = wd;
      end
      if (wr_cmpb[i]) begin
        st_next.tmr[i].cmpb = wd;
      end
      if (wr_ctl[i]) begin
        if (wd[`TTU_B_GATE]) begin
          st_next.tmr[i].en = wd[`TTU_B_EN];
        end
        st_next.tmr[i].int_en = wd[`TTU_B_INT];
        st_next.tmr[i].maxcount_flag = wd[`TTU_B_MC];
        st_next.tmr[i].free_run_select = wd[`TTU_B_FREE_RUN_SELECT];
        if (i < 2) begin
          st_next.tmr[i].retrigger_select = wd[`TTU_B_RTG];
          st_next.tmr[i].pre = wd[`TTU_B_PRE];
          st_next.tmr[i].outside_clock_select = wd[`TTU_B_EXT];
          st_next.tmr[i].dual_compare_select = wd[`TTU_B_ALT];
        end
      end
      // a maxcount event beats a clearing write in the same cycle
      if (hit[i]) begin
        st_next.tmr[i].maxcount_flag = 1'b1;
      end
      // pending request ignores the enable bit and set beats ack
      if (i_irq_ack[i]) begin
        st_next.irq[i] = 1'b0;
      end
      if (hit[i] && st_reg.tmr[i].int_en) begin
        st_next.irq[i] = 1'b1;
      end
    end
    for (int i = 0; i < 2; i++) begin
      // high through the A phase, low through the B phase
      st_next.wave[i] = !(st_next.tmr[i].dual_compare_select &&
        st_next.tmr[i].second_compare_active);
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign o_apb = st_reg.rsp;
  assign o_irq_req = st_reg.irq;
  assign o_timer0_wave_output = st_reg.wave[0];
  assign o_timer1_wave_output = st_reg.wave[1];

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);

  generate
    for (gi = 0; gi < 3; gi++) begin : g_chk
      sequence hit_s;
        hit[gi] && !wr_cnt[gi] && !wr_ctl[gi];
      endsequence
      sequence dual_hit_s;
        hit_s ##0 st_reg.tmr[gi].dual_compare_select;
      endsequence

      count_hold_a: assert property (!st_reg.tmr[gi].en && !wr_cnt[gi] |=> $stable(st_reg.tmr[gi].cnt))
        else $error("count moved while disabled");
      gate_guard_a: assert property (wr_ctl[gi] && !wd[`TTU_B_GATE] && !hit[gi] |=>
        st_reg.tmr[gi].en == $past(st_reg.tmr[gi].en))
        else $error("enable changed without gate");
      irq_raise_a: assert property (hit[gi] && st_reg.tmr[gi].int_en |=> o_irq_req[gi])
        else $error("request missing at maxcount");
      irq_quiet_a: assert property (!o_irq_req[gi] && !(hit[gi] && st_reg.tmr[gi].int_en) |=> !o_irq_req[gi])
        else $error("request without cause");
      irq_hold_a: assert property (o_irq_req[gi] && !i_irq_ack[gi] |=> o_irq_req[gi])
        else $error("pending request lost");
      phase_flip_a: assert property (dual_hit_s |=>
        st_reg.tmr[gi].second_compare_active != $past(st_reg.tmr[gi].second_compare_active))
        else $error("compare phase did not alternate");
      flag_set_a: assert property (hit[gi] |=> st_reg.tmr[gi].maxcount_flag)
        else $error("maxcount flag not set");
      match_clear_a: assert property (hit_s |=> st_reg.tmr[gi].cnt == `TTU_RST16)
        else $error("count not cleared on match");
      single_stop_a: assert property (hit_s ##0 !st_reg.tmr[gi].free_run_select ##0
        (!st_reg.tmr[gi].dual_compare_select || st_reg.tmr[gi].second_compare_active) |=> !st_reg.tmr[gi].en)
        else $error("single run did not stop");
    end
  endgenerate

  quarter_rate_a: assert property (!int_tick && !wr_cnt[2] |=> $stable(st_reg.tmr[2].cnt))
    else $error("timer 2 stepped off the quarter clock");
  prescale_a: assert property (st_reg.tmr[0].en && st_reg.tmr[0].pre && !st_reg.tmr[0].outside_clock_select &&
    !hit[2] && !wr_cnt[0] |=> $stable(st_reg.tmr[0].cnt))
    else $error("prescaled timer stepped without timer 2 maxcount");
  wave_phase_a: assert property (st_reg.tmr[1].dual_compare_select |->
    o_timer1_wave_output == !st_reg.tmr[1].second_compare_active)
    else $error("wave output off phase");
endmodule

/* File: verification/ttu_tb.sv */
`timescale 1ns/1ps
`include "ttu_cfg.svh"
module testbench
  import ttu_pkg::*;
;
  // ****************************************
  // signals
  // ****************************************
  logic i_clk_sys;
  logic i_rst;
  ttu_apb_req_t apb_req;
  ttu_apb_rsp_t apb_rsp;
  logic pin0;
  logic pin1;
  logic [2:0] ack;
  logic [2:0] req;
  logic wave0;
  logic wave1;
  int err_count;
  int compares;
  int cycles;
  logic [31:0] rd;
  logic er;
  time t1;
  time t2;
  logic w1;
  logic w2;

  ttu_top dut_u (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_apb(apb_req),
    .o_apb(apb_rsp),
    .i_timer0_count_input(pin0),
    .i_timer1_count_input(pin1),
    .i_irq_ack(ack),
    .o_irq_req(req),
    .o_timer0_wave_output(wave0),
    .o_timer1_wave_output(wave1)
  );

  // ****************************************
  // clock, timeout and report
  // ****************************************
  initial begin
    i_clk_sys = 1'b0;
    forever #12.5 i_clk_sys = ~i_clk_sys;
  end

  task automatic tally_and_finish();
    $display("mismatches %0d, comparisons %0d", err_count, compares);
    if (err_count == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // every scenario is short; a stuck wait ends the run here
  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      tally_and_finish();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  // ****************************************
  // apb master
  // ****************************************
  // request held until pready is sampled; only the bench timeout ends a stuck wait
  // the slave answers with no wait state, so one access cycle is expected
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [15:0] wd);
    int n;
    n = 0;
    @(posedge i_clk_sys);
    apb_req.paddr <= {2'h0, idx, 2'h0};
    apb_req.psel <= 1'b1;
    apb_req.penable <= 1'b0;
    apb_req.pwrite <= wr;
    apb_req.pwdata <= {16'h0000, wd};
    @(posedge i_clk_sys);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge i_clk_sys);
      n++;
    end while (apb_rsp.pready !== 1'b1);
    rd = apb_rsp.prdata;
    er = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
    check(n, 32'h1);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [15:0] wd);
    apb(1'b1, idx, wd);
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [15:0] exp);
    apb(1'b0, idx, 16'h0000);
    check(rd, {16'h0000, exp});
  endtask

  // waits for a request, notes time and wave level, optionally acknowledges
  task automatic wait_irq(input int i, input logic do_ack, output time t, output logic w);
    int n;
    n = 0;
    do begin
      @(posedge i_clk_sys);
      n++;
    end while (req[i] !== 1'b1 && n < 2000);
    t = $time;
    w = (i == 1) ? wave1 : wave0;
    check(32'(n < 2000), 32'h1);
    if (do_ack) begin
      ack[i] <= 1'b1;
      @(posedge i_clk_sys);
      ack[i] <= 1'b0;
    end
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    rd_chk(`TTU_IDX_T0_CNT, 16'h0000);
    rd_chk(`TTU_IDX_T0_CMPA, 16'h0000);
    rd_chk(`TTU_IDX_T0_CMPB, 16'h0000);
    rd_chk(`TTU_IDX_T0_CTL, 16'h0000);
    rd_chk(`TTU_IDX_T1_CNT, 16'h0000);
    rd_chk(`TTU_IDX_T1_CMPA, 16'h0000);
    rd_chk(`TTU_IDX_T1_CMPB, 16'h0000);
    rd_chk(`TTU_IDX_T1_CTL, 16'h0000);
    rd_chk(`TTU_IDX_T2_CNT, 16'h0000);
    rd_chk(`TTU_IDX_T2_CMPA, 16'h0000);
    rd_chk(`TTU_IDX_T2_CTL, 16'h0000);
    check({29'h0, req}, 32'h0);
    apb(1'b0, 8'h70, 16'h0000);
    check({rd[31:1], er}, 32'h1);
    wr(`TTU_IDX_T0_CTL, 16'h8001);
    rd_chk(`TTU_IDX_T0_CTL, 16'h0001);
    wr(`TTU_IDX_T2_CTL, 16'h7fde);
    rd_chk(`TTU_IDX_T2_CTL, 16'h2000);
  endtask

  task automatic t_single_cmp();
    wr(`TTU_IDX_T0_CMPA, 16'h0005);
    wr(`TTU_IDX_T0_CTL, 16'he001);
    wait_irq(0, 1'b1, t1, w1);
    wait_irq(0, 1'b1, t2, w2);
    check(32'(t2 - t1), 32'd500);
    rd_chk(`TTU_IDX_T0_CTL, 16'ha021);
    wait_irq(0, 1'b0, t1, w1);
    wr(`TTU_IDX_T0_CTL, 16'h6000);
    check({31'h0, req[0]}, 32'h1);
    apb(1'b0, `TTU_IDX_T0_CNT, 16'h0000);
    repeat (40) @(posedge i_clk_sys);
    rd_chk(`TTU_IDX_T0_CNT, rd[15:0]);
    ack[0] <= 1'b1;
    @(posedge i_clk_sys);
    ack[0] <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
    check({31'h0, req[0]}, 32'h0);
  endtask

  task automatic t_dual();
    wr(`TTU_IDX_T1_CMPA, 16'h0003);
    wr(`TTU_IDX_T1_CMPB, 16'h0006);
    wr(`TTU_IDX_T1_CTL, 16'he003);
    wait_irq(1, 1'b1, t1, w1);
    wait_irq(1, 1'b1, t2, w2);
    check(32'(t2 - t1), w1 ? 32'd300 : 32'd600);
    check({31'h0, w2}, {31'h0, ~w1});
    apb(1'b0, `TTU_IDX_T1_CTL, 16'h0000);
    check({31'h0, rd[12]}, {31'h0, ~w2});
    wait_irq(1, 1'b1, t1, w1);
    check(32'(t1 - t2), w2 ? 32'd300 : 32'd600);
    wr(`TTU_IDX_T1_CTL, 16'h4000);
  endtask

  task automatic t_single_run();
    wr(`TTU_IDX_T0_CNT, 16'h0000);
    wr(`TTU_IDX_T0_CMPA, 16'h0002);
    wr(`TTU_IDX_T0_CTL, 16'he000);
    wait_irq(0, 1'b1, t1, w1);
    rd_chk(`TTU_IDX_T0_CTL, 16'h2020);
    wr(`TTU_IDX_T0_CTL, 16'h2000);
    rd_chk(`TTU_IDX_T0_CTL, 16'h2000);
    wr(`TTU_IDX_T0_CNT, 16'hfffe);
    wr(`TTU_IDX_T0_CMPA, 16'h0000);
    wr(`TTU_IDX_T0_CTL, 16'hc000);
    repeat (16) @(posedge i_clk_sys);
    check({31'h0, req[0]}, 32'h0);
    rd_chk(`TTU_IDX_T0_CTL, 16'h0020);
    rd_chk(`TTU_IDX_T0_CNT, 16'h0000);
  endtask

  task automatic t_pin();
    wr(`TTU_IDX_T1_CNT, 16'h0000);
    wr(`TTU_IDX_T1_CMPA, 16'h0000);
    wr(`TTU_IDX_T1_CTL, 16'hc00d);
    repeat (7) begin
      @(posedge i_clk_sys);
      pin1 <= 1'b1;
      repeat (6) @(posedge i_clk_sys);
      pin1 <= 1'b0;
      repeat (3) @(posedge i_clk_sys);
    end
    repeat (6) @(posedge i_clk_sys);
    rd_chk(`TTU_IDX_T1_CNT, 16'h0007);
    wr(`TTU_IDX_T1_CTL, 16'h4000);
  endtask

  task automatic t_prescale();
    wr(`TTU_IDX_T2_CMPA, 16'h0002);
    wr(`TTU_IDX_T2_CTL, 16'hc001);
    wr(`TTU_IDX_T0_CNT, 16'h0000);
    wr(`TTU_IDX_T0_CMPA, 16'h0003);
    wr(`TTU_IDX_T0_CTL, 16'he009);
    wait_irq(0, 1'b1, t1, w1);
    wait_irq(0, 1'b1, t2, w2);
    check(32'(t2 - t1), 32'd600);
    check({31'h0, req[2]}, 32'h0);
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    err_count = 0;
    compares = 0;
    cycles = 0;
    i_rst = 1'b1;
    apb_req = '0;
    pin0 = 1'b0;
    pin1 = 1'b0;
    ack = 3'h0;
    repeat (20) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
    check({31'h0, wave0 & wave1}, 32'h1);
    t_reset();
    t_single_cmp();
    t_dual();
    t_single_run();
    t_pin();
    t_prescale();
    tally_and_finish();
  end
endmodule
